// File: design/lbb_consts.vh
// constants for the led bank register block
`ifndef LBB_CONSTS_VH
`define LBB_CONSTS_VH

// ----------------------------------------
// bus addresses
// ----------------------------------------
`define LBB_ADDR_STD 7'h36
`define LBB_ADDR_ALT 7'h38

// ----------------------------------------
// register offsets and reset values
// ----------------------------------------
`define LBB_REG_CFG 8'h10
`define LBB_REG_MAIN 8'ha0
`define LBB_REG_AUX 8'hb0
`define LBB_REG_IND 8'hc0
`define LBB_RST_CFG 8'h20
`define LBB_RST_MAIN 8'he0
`define LBB_RST_AUX 8'he0
`define LBB_RST_IND 8'hfc

// ----------------------------------------
// field positions and fixed bits
// ----------------------------------------
`define LBB_CFG_MAIN_ON 0
`define LBB_CFG_AUX_ON 1
`define LBB_CFG_IND_ON 2
`define LBB_CFG_SENSE5 3
`define LBB_CFG_SINK3 4
`define LBB_CFG_FIXED 3'h1
`define LBB_LVL_FIXED 3'h7
`define LBB_IND_FIXED 6'h3f

// ----------------------------------------
// timing
// ----------------------------------------
`define LBB_CLK_HZ 200000000
`define LBB_PWM_HZ 20000
// one pwm period is sixteen slots
`define LBB_SLOT_CYC (`LBB_CLK_HZ / `LBB_PWM_HZ / 16)

// ----------------------------------------
// analog scale codes
// ----------------------------------------
`define LBB_AN_20 2'h0
`define LBB_AN_40 2'h1
`define LBB_AN_70 2'h2
`define LBB_AN_100 2'h3

`endif

// File: design/lbb_pwm.v
// pwm generator: shared 16-slot counter at 20 khz, duty per group
`include "lbb_consts.vh"
module lbb_pwm #(
	parameter SLOT_CYC = `LBB_SLOT_CYC
)
(
	// clock and reset
	input wire clk,
	input wire rst,
	// duty in sixteenths minus one
	input wire [3:0] duty_a,
	input wire [3:0] duty_b,
	// pwm outputs
	output reg pwm_a,
	output reg pwm_b
);

	reg [15:0] div_q;
	reg [3:0] slot_q;

	// ----------------------------------------
	// period counter
	// ----------------------------------------
	always @(posedge clk)
	begin
		if (rst)
		begin
			div_q <= 16'h0000;
			slot_q <= 4'h0;
			pwm_a <= 1'b0;
			pwm_b <= 1'b0;
		end
		else
		begin
			if (div_q == SLOT_CYC[15:0] - 16'h0001)
			begin
				div_q <= 16'h0000;
				slot_q <= slot_q + 4'h1;
			end
			else
			begin
				div_q <= div_q + 16'h0001;
			end
			// on for duty+1 of 16 slots
			pwm_a <= (slot_q <= duty_a);
			pwm_b <= (slot_q <= duty_b);
		end
	end

endmodule

// File: design/lbb_top.v
// led bank register block: two-wire slave, registers and brightness decode
// ----------------------------------------
// Summary of operation
// - answer only to address 36h, or 38h when alternate option strap set
// - write: first byte after address picks register, next byte is data
// - configuration register at internal address 10h
// - main, aux, indicator level registers at a0h, b0h, c0h
// - config bit 0 switches main group
// - config bit 1 switches aux group
// - config bit 2 switches indicator sink
// - config bit 3 enables fifth main sink voltage sensing
// - config bit 4 enables third aux sink and its sensing together
// - main level low five bits, 11111 is full scale
// - aux level low five bits, 11111 is full scale
// - level bits 7..5 unused, read as ones, writes ignored
// - indicator level low two bits, 11 is full scale
// - indicator bits 7..2 unused and ignored
// - indicator codes give 20/40/70/100 percent analog, no pwm
// - codes 00..0f: 20 percent analog, duty (code+1)/16
// - codes 10..1f: 40, 70, 100 percent bands per table duties
// - pwm runs at fixed 20 khz
// - reset pin low restores power-on values and disables device
// - acknowledge a matching address byte and every later received byte by pulling data low on ninth clock
// - direction bit 0 is write, 1 is read
// ----------------------------------------
`include "lbb_consts.vh"
module lbb_top #(
	parameter SLOT_CYC = `LBB_SLOT_CYC
)
(
	// clock and synchronous reset
	input wire clk,
	input wire rst,
	// device pins
	input wire reset_n_pin,
	input wire addr_alt,
	input wire scl_in,
	input wire sda_in,
	output reg sda_out,
	output reg sda_oe,
	// group drive
	output reg main_group_on,
	output reg aux_group_on,
	output reg indicator_on,
	output reg fifth_main_sense_on,
	output reg third_aux_sink_on,
	output reg [1:0] main_analog,
	output reg [1:0] aux_analog,
	output reg [1:0] indicator_analog,
	output wire main_pwm,
	output wire aux_pwm
);

	localparam ST_IDLE = 4'b0001;
	localparam ST_RECV = 4'b0010;
	localparam ST_ACK = 4'b0100;
	localparam ST_SEND = 4'b1000;

	// full reset bytes, sliced down to the stored fields below
	localparam [7:0] RST_CFG = `LBB_RST_CFG;
	localparam [7:0] RST_MAIN = `LBB_RST_MAIN;
	localparam [7:0] RST_AUX = `LBB_RST_AUX;
	localparam [7:0] RST_IND = `LBB_RST_IND;

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	reg [1:0] scl_s_q;
	reg [1:0] sda_s_q;
	reg [1:0] rstn_s_q;
	reg [1:0] alt_s_q;
	reg scl_d1_q;
	reg sda_d1_q;
	always @(posedge clk)
	begin
		scl_s_q <= {scl_s_q[0], scl_in};
		sda_s_q <= {sda_s_q[0], sda_in};
		rstn_s_q <= {rstn_s_q[0], reset_n_pin};
		alt_s_q <= {alt_s_q[0], addr_alt};
		scl_d1_q <= scl_s_q[1];
		sda_d1_q <= sda_s_q[1];
	end

	wire scl = scl_s_q[1];
	wire sda = sda_s_q[1];
	wire scl_rise = scl & ~scl_d1_q;
	wire scl_fall = ~scl & scl_d1_q;
	wire start_c = scl & scl_d1_q & sda_d1_q & ~sda;
	wire stop_c = scl & scl_d1_q & ~sda_d1_q & sda;
	wire clr = rst | ~rstn_s_q[1];

	// ----------------------------------------
	// level code decode
	// ----------------------------------------
	// returns {analog[1:0], duty_minus_one[3:0]}
	function [5:0] level_map;
		input [4:0] code;
		begin
			if (code[4] == 1'b0)
				level_map = {`LBB_AN_20, code[3:0]};
			else if (code <= 5'h16)
				level_map = {`LBB_AN_40, code[3:0] + 4'h9};
			else if (code <= 5'h1c)
				level_map = {`LBB_AN_70, code[3:0] + 4'h3};
			else if (code == 5'h1d)
				level_map = {`LBB_AN_100, 4'hc};
			else if (code == 5'h1e)
				level_map = {`LBB_AN_100, 4'he};
			else
				level_map = {`LBB_AN_100, 4'hf};
		end
	endfunction

	// ----------------------------------------
	// serial slave
	// ----------------------------------------
	reg [3:0] st_q;
	reg [3:0] bit_q;
	reg [7:0] sh_q;
	reg [1:0] byte_q;
	reg rd_q;
	reg [7:0] ptr_q;
	reg [4:0] cfg_q;
	reg [4:0] main_level_code;
	reg [4:0] aux_level_code;
	reg [1:0] indicator_level_code;
	reg [7:0] rd_byte;

	always @*
	begin
		case (ptr_q)
			`LBB_REG_CFG: rd_byte = {`LBB_CFG_FIXED, cfg_q};
			`LBB_REG_MAIN: rd_byte = {`LBB_LVL_FIXED, main_level_code};
			`LBB_REG_AUX: rd_byte = {`LBB_LVL_FIXED, aux_level_code};
			`LBB_REG_IND: rd_byte = {`LBB_IND_FIXED, indicator_level_code};
			default: rd_byte = 8'h00;
		endcase
	end

	wire [6:0] my_addr = alt_s_q[1] ? `LBB_ADDR_ALT : `LBB_ADDR_STD;

	always @(posedge clk)
	begin
		if (clr)
		begin
			st_q <= ST_IDLE;
			bit_q <= 4'h0;
			sh_q <= 8'h00;
			byte_q <= 2'h0;
			rd_q <= 1'b0;
			ptr_q <= 8'h00;
			sda_out <= 1'b0;
			sda_oe <= 1'b0;
			cfg_q <= RST_CFG[4:0];
			main_level_code <= RST_MAIN[4:0];
			aux_level_code <= RST_AUX[4:0];
			indicator_level_code <= RST_IND[1:0];
		end
		else if (start_c)
		begin
			st_q <= ST_RECV;
			bit_q <= 4'h0;
			byte_q <= 2'h0;
			sda_oe <= 1'b0;
		end
		else if (stop_c)
		begin
			st_q <= ST_IDLE;
			sda_oe <= 1'b0;
		end
		else
		begin
			case (st_q)
				ST_IDLE:
				begin
					sda_oe <= 1'b0;
				end
				ST_RECV:
				begin
					if (scl_rise)
					begin
						sh_q <= {sh_q[6:0], sda};
						bit_q <= bit_q + 4'h1;
					end
					else if (scl_fall && bit_q == 4'h8)
					begin
						bit_q <= 4'h0;
						if (byte_q == 2'h0 && sh_q[7:1] != my_addr)
						begin
							st_q <= ST_IDLE;
						end
						else
						begin
							// pull data low through the ninth clock
							st_q <= ST_ACK;
							sda_oe <= 1'b1;
							sda_out <= 1'b0;
							if (byte_q == 2'h0)
								rd_q <= sh_q[0];
							else if (byte_q == 2'h1)
								ptr_q <= sh_q;
							else
							begin
								case (ptr_q)
									`LBB_REG_CFG: cfg_q <= sh_q[4:0];
									`LBB_REG_MAIN: main_level_code <= sh_q[4:0];
									`LBB_REG_AUX: aux_level_code <= sh_q[4:0];
									`LBB_REG_IND: indicator_level_code <= sh_q[1:0];
									default: ;
								endcase
							end
							if (byte_q != 2'h2)
								byte_q <= byte_q + 2'h1;
						end
					end
				end
				ST_ACK:
				begin
					if (scl_fall)
					begin
						if (rd_q)
						begin
							// read returns the selected register
							st_q <= ST_SEND;
							sh_q <= rd_byte;
							sda_out <= rd_byte[7];
							sda_oe <= ~rd_byte[7];
							bit_q <= 4'h1;
						end
						else
						begin
							st_q <= ST_RECV;
							sda_oe <= 1'b0;
						end
					end
				end
				ST_SEND:
				begin
					if (scl_fall)
					begin
						if (bit_q == 4'h8)
						begin
							sda_oe <= 1'b0;
							st_q <= ST_IDLE;
						end
						else
						begin
							sda_out <= sh_q[3'h7 - bit_q[2:0]];
							sda_oe <= ~sh_q[3'h7 - bit_q[2:0]];
							bit_q <= bit_q + 4'h1;
						end
					end
				end
				default:
				begin
					st_q <= ST_IDLE;
					sda_oe <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// group drive outputs
	// ----------------------------------------
	wire [5:0] main_map = level_map(main_level_code);
	wire [5:0] aux_map = level_map(aux_level_code);
	wire pa;
	wire pb;

	always @(posedge clk)
	begin
		if (clr)
		begin
			main_group_on <= 1'b0;
			aux_group_on <= 1'b0;
			indicator_on <= 1'b0;
			fifth_main_sense_on <= 1'b0;
			third_aux_sink_on <= 1'b0;
			main_analog <= 2'h0;
			aux_analog <= 2'h0;
			indicator_analog <= 2'h0;
		end
		else
		begin
			main_group_on <= cfg_q[`LBB_CFG_MAIN_ON];
			aux_group_on <= cfg_q[`LBB_CFG_AUX_ON];
			indicator_on <= cfg_q[`LBB_CFG_IND_ON];
			fifth_main_sense_on <= cfg_q[`LBB_CFG_SENSE5];
			third_aux_sink_on <= cfg_q[`LBB_CFG_SINK3];
			main_analog <= main_map[5:4];
			aux_analog <= aux_map[5:4];
			indicator_analog <= indicator_level_code;
		end
	end

	lbb_pwm #(
		.SLOT_CYC(SLOT_CYC)
	) u_pwm (
		.clk(clk),
		.rst(clr),
		.duty_a(main_map[3:0]),
		.duty_b(aux_map[3:0]),
		.pwm_a(pa),
		.pwm_b(pb)
	);

	// pwm gated by group enable so a disabled group never pulses
	assign main_pwm = pa & main_group_on;
	assign aux_pwm = pb & aux_group_on;

endmodule

// File: bench/lbb_monitor.sv
// assertion checker for the led bank register block
`include "lbb_consts.vh"
module lbb_monitor #(
	parameter SLOT_CYC = `LBB_SLOT_CYC
)
(
	// clock and resets
	input wire clk,
	input wire rst,
	input wire reset_n_pin,
	// bus
	input wire scl_in,
	input wire sda_oe,
	// group drive
	input wire main_group_on,
	input wire aux_group_on,
	input wire indicator_on,
	input wire [1:0] main_analog,
	input wire main_pwm,
	input wire aux_pwm
);
	timeunit 1ns;
	timeprecision 100ps;
	// dark run of each pwm while its group is on; slot 0 is always lit
	logic [15:0] lo_main_q;
	logic [15:0] lo_aux_q;
	always @(posedge clk)
	begin
		if (rst || !main_group_on || main_pwm)
			lo_main_q <= 16'h0000;
		else
			lo_main_q <= lo_main_q + 16'h0001;
		if (rst || !aux_group_on || aux_pwm)
			lo_aux_q <= 16'h0000;
		else
			lo_aux_q <= lo_aux_q + 16'h0001;
	end
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	chk_rst_clear:
	assert property ($fell(rst) |-> !sda_oe && !main_group_on && main_analog == 2'h0)
		else $error("outputs not cleared by reset");
	chk_pin_reset:
	assert property (!reset_n_pin [*6] |-> !sda_oe && !aux_group_on && !indicator_on)
		else $error("reset pin did not clear outputs");
	chk_ack_scl_low:
	assert property ($rose(sda_oe) |-> !scl_in)
		else $error("ack raised while scl high");
	chk_rel_scl_low:
	assert property ($fell(sda_oe) |-> !scl_in)
		else $error("ack released while scl high");
	chk_ack_length:
	assert property ($rose(sda_oe) |-> sda_oe [*8] ##[10:30] !sda_oe)
		else $error("ack length wrong");
	chk_main_duty:
	assert property (lo_main_q < 16 * SLOT_CYC)
		else $error("main pwm dark for a whole period");
	chk_aux_duty:
	assert property (lo_aux_q < 16 * SLOT_CYC)
		else $error("aux pwm dark for a whole period");
	chk_cfg_in_frame:
	assert property ($changed(main_group_on) && reset_n_pin |-> !scl_in)
		else $error("group switched outside a data byte");
	cover property ($rose(sda_oe));
	cover property (main_pwm && !aux_pwm);
	cover property ($rose(indicator_on));
endmodule

bind lbb_top lbb_monitor #(.SLOT_CYC(SLOT_CYC)) mon_u (.clk(clk), .rst(rst),
	.reset_n_pin(reset_n_pin), .scl_in(scl_in), .sda_oe(sda_oe),
	.main_group_on(main_group_on), .aux_group_on(aux_group_on),
	.indicator_on(indicator_on), .main_analog(main_analog),
	.main_pwm(main_pwm), .aux_pwm(aux_pwm));

// File: bench/lbb_master.sv
// two-wire bus master model; scl stands high between frames
module lbb_master (
	// bus lines
	output logic scl,
	input wire sda,
	output logic sda_low
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam realtime q = 31.25;
	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// data only moves while scl is low
	task automatic bit_t(input logic x, output logic v);
		#q sda_low = !x;
		#q scl = 1'b1;
		#q v = sda;
		#q scl = 1'b0;
	endtask
	task automatic tx(input logic [7:0] b, output logic a);
		logic v;
		for (int i = 7; i >= 0; i--)
			bit_t(b[i], v);
		bit_t(1'b1, v);
		a = !v;
	endtask
	task automatic wr(input logic [6:0] ad, input logic [7:0] r, d, output logic [2:0] k);
		sda_low = 1'b1;
		#q scl = 1'b0;
		tx({ad, 1'b0}, k[2]);
		tx(r, k[1]);
		tx(d, k[0]);
		#q sda_low = 1'b1;
		#q scl = 1'b1;
		#q sda_low = 1'b0;
		#q;
	endtask
	// one-byte read of the register picked by the last write, then nack and stop
	task automatic rd(input logic [6:0] ad, output logic [7:0] d, output logic a);
		logic v;
		sda_low = 1'b1;
		#q scl = 1'b0;
		tx({ad, 1'b1}, a);
		for (int i = 7; i >= 0; i--)
		begin
			bit_t(1'b1, v);
			d[i] = v;
		end
		bit_t(1'b1, v);
		#q sda_low = 1'b1;
		#q scl = 1'b1;
		#q sda_low = 1'b0;
		#q;
	endtask
endmodule

// File: bench/lbb_top_tb_top.sv
// self-checking bench for the led bank register block
module lbb_top_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 0, rst = 1, rn = 1, alt = 0, smp = 0;
	logic [2:0] k = 0;
	logic [6:0] mc, ac;
	logic [7:0] lf = 8'h13, cfg, lm, la, li;
	logic [27:0] q [$], e;
	logic [8:0] rq [$], rx;
	logic [7:0] rb = 8'h00;
	logic ra = 0, rdv = 0;
	int fails = 0, checked = 0, cyc = 0;
	wire scl, ml, so, oe, mon, aon, ion, s5, s3, mp, ap;
	wire [1:0] ma, aa, ia;
	// open drain: the device pulls only when enabled and driving a zero
	wire sda = !((oe && !so) || ml);
	wire [27:0] got = {k, mon, aon, ion, s5, s3, ma, aa, ia, mc, ac};
	always #2.5 clk = !clk;
	lbb_master m_u (.scl(scl), .sda(sda), .sda_low(ml));
	lbb_top #(.SLOT_CYC(4)) dut_u (.clk(clk), .rst(rst), .reset_n_pin(rn),
		.addr_alt(alt), .scl_in(scl), .sda_in(sda), .sda_out(so), .sda_oe(oe),
		.main_group_on(mon), .aux_group_on(aon), .indicator_on(ion),
		.fifth_main_sense_on(s5), .third_aux_sink_on(s3), .main_analog(ma),
		.aux_analog(aa), .indicator_analog(ia), .main_pwm(mp), .aux_pwm(ap));
	function automatic logic [7:0] rnd();
		lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
		return lf;
	endfunction
	function automatic logic [1:0] an(input logic [4:0] c);
		return c < 5'h10 ? 2'h0 : c < 5'h17 ? 2'h1 : c < 5'h1d ? 2'h2 : 2'h3;
	endfunction
	// high count over one 64-cycle period
	function automatic logic [6:0] dc(input logic [4:0] c, input logic on);
		logic [6:0] d;
		d = c < 5'h10 ? c + 1 : c < 5'h17 ? c - 6 : c < 5'h1d ? c - 12 : c == 5'h1d ? 13 : c == 5'h1e ? 15 : 16;
		return on ? {d[4:0], 2'b00} : 7'h0;
	endfunction
	task automatic rst_model();
		cfg = 8'h20;
		lm = 8'he0;
		la = 8'he0;
		li = 8'hfc;
		k = 3'h0;
	endtask
	task automatic note(input logic [2:0] ka);
		q.push_back({ka, cfg[0], cfg[1], cfg[2], cfg[3], cfg[4], an(lm[4:0]), an(la[4:0]),
			li[1:0], dc(lm[4:0], cfg[0]), dc(la[4:0], cfg[1])});
	endtask
	task automatic obs();
		repeat (80) @(negedge clk);
		mc = 0;
		ac = 0;
		repeat (64)
		begin
			@(negedge clk);
			mc = mc + mp;
			ac = ac + ap;
		end
		smp = 1;
		@(negedge clk);
		smp = 0;
	endtask
	task automatic go(input logic [6:0] a, input logic [7:0] r, d);
		logic ok;
		ok = a == (alt ? 7'h38 : 7'h36);
		m_u.wr(a, r, d, k);
		if (ok)
			case (r)
				8'h10: cfg = d;
				8'ha0: lm = d;
				8'hb0: la = d;
				8'hc0: li = d;
				default: ;
			endcase
		note(ok ? 3'h7 : 3'h0);
		obs();
	endtask
	task automatic rdb(input logic [7:0] x);
		rq.push_back({1'b1, x});
		m_u.rd(alt ? 7'h38 : 7'h36, rb, ra);
		@(negedge clk);
		rdv = 1;
		@(negedge clk);
		rdv = 0;
	endtask
	task automatic conclude();
		$display("checked=%0d fails=%0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 90000)
		begin
			fails++;
			conclude();
		end
		if (smp)
		begin
			e = q.pop_front();
			checked++;
			if (e !== got)
			begin
				fails++;
				$display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, got);
			end
		end
		if (rdv)
		begin
			rx = rq.pop_front();
			checked++;
			if (rx !== {ra, rb})
			begin
				fails++;
				$display("CHECK FAILED t=%0t exp=%h got=%h", $time, rx, {ra, rb});
			end
		end
	end
	initial
	begin
		rst_model();
		repeat (5) @(negedge clk);
		rst = 0;
		repeat (5) @(negedge clk);
		note(3'h0);
		obs();
		go(7'h36, 8'h10, 8'h1f);
		for (int i = 0; i < 32; i++)
		begin
			go(7'h36, 8'ha0, rnd() & 8'he0 | 8'(i));
			go(7'h36, 8'hb0, rnd() & 8'he0 | 8'(31 - i));
		end
		go(7'h36, 8'ha0, rnd() & 8'he0 | 8'h15);
		rdb(8'hf5);
		for (int i = 0; i < 4; i++)
			go(7'h36, 8'hc0, rnd() & 8'hfc | 8'(i));
		go(7'h36, 8'h10, rnd());
		go(7'h36, 8'h40, rnd());
		go(7'h38, 8'h10, 8'h00);
		alt = 1;
		go(7'h38, 8'h10, rnd());
		go(7'h36, 8'h10, 8'h00);
		rn = 0;
		repeat (6) @(negedge clk);
		rn = 1;
		rst_model();
		note(3'h0);
		obs();
		conclude();
	end
endmodule
